// *** pin_sync.sv ***
// Three-stage pin synchroniser, output moves once stages two and three agree
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  // First stage feeds only the second; agreement of two and three counts
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
        nxt_st.q[i] = st_ff.s3[i];
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign level_out = st_ff.q;
endmodule : pin_sync

// *** pwr_clk_ctrl.sv ***
// Stop mode, clock source, supply reset and early-warning control
//
// The APB slave port was decided locally.
`include "pwr_clk_regs.svh"
module pwr_clk_ctrl #(
  parameter int ADDR_W        = 10,
  parameter int SETTLE_CLOCKS = `OSC_SETTLE_COUNT
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic                   pready_out,
  output logic      [31:0]       prdata_out,
  output logic                   pslverr_out,
  // Pins: crystal clock, external wake, supply comparators
  input  wire logic              crystal_clk_in,
  input  wire logic              ext_wake_in,
  input  wire logic              supply_ok_in,
  input  wire logic              supply_warn_ok_in,
  // Bus cycle status from the core
  input  wire logic              external_data_move_in,
  // Reset, power and clock controls
  output logic                   cpu_reset_out,
  output logic                   stop_mode_out,
  output logic                   core_crystal_frequency_gate_out,
  output logic                   core_ring_gate_out,
  output logic                   crystal_enable_out,
  output logic                   ring_osc_enable_out,
  output logic                   reference_on_out,
  // Strobe, timer rates, power-fail request
  output logic                   strobe_out,
  output logic      [2:0]        timer_tick_out,
  output logic                   serial1_baud_tick_out,
  output logic                   early_supply_warning_irq_out,
  output logic      [15:0]       irq_vector_out
);
  localparam logic [16:0] CNT_LAST = 17'(SETTLE_CLOCKS - 1);

  initial
  begin
    if (ADDR_W < 10 || SETTLE_CLOCKS < 1 || SETTLE_CLOCKS > 131072)
      $error("pwr_clk_ctrl: unsupported parameter value");
  end

  // Byte-address match of a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction : hit

  // Last divider count for a timer rate bit
  function automatic logic [3:0] tmr_last(input logic fast);
    tmr_last = fast ? `TMR_FAST_LAST : `TMR_SLOW_LAST;
  endfunction : tmr_last

  pwr_clk_pkg::ctrl_state_t st_ff;
  pwr_clk_pkg::ctrl_state_t nxt_st;
  logic [3:0] sy;
  logic       xt_tick;
  logic       wake_rise;
  logic       supply_low;
  logic       warn_low;
  logic       setup;
  logic       wr;
  logic       wr_power_control_reg;
  logic       wr_clock_control_reg;
  logic       wr_extended_flag_reg;
  logic       wr_ta;
  logic       wr_pmr;
  logic       wr_wd;
  logic       settle_done;
  logic       pf_wake;

  // Pin synchronisers: crystal, wake, supply ok, warning ok
  pin_sync #(
    .W (4)
  ) u_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    ({supply_warn_ok_in, supply_ok_in, ext_wake_in,
                 crystal_clk_in}),
    .level_out (sy)
  );

  // Events and bus decode
  assign xt_tick     = sy[0] & ~st_ff.xt_prev;
  assign wake_rise   = sy[1] & ~st_ff.wake_prev;
  // Comparators are blind while the reference is off
  assign supply_low  = ~sy[2] & st_ff.ref_on;
  assign warn_low    = ~sy[3] & st_ff.ref_on;
  assign setup       = psel_in & ~penable_in;
  assign wr          = psel_in & penable_in & pwrite_in & st_ff.pready
                       & pstrb_in[0];
  assign wr_power_control_reg     = wr & hit(paddr_in, `IDX_POWER_CTRL);
  assign wr_clock_control_reg    = wr & hit(paddr_in, `IDX_CLOCK_CTRL);
  assign wr_extended_flag_reg     = wr & hit(paddr_in, `IDX_EXT_FLAG);
  assign wr_ta       = wr & hit(paddr_in, `IDX_TIMED_ACCESS);
  assign wr_pmr      = wr & hit(paddr_in, `IDX_POWER_MGMT);
  assign wr_wd       = wr & hit(paddr_in, `IDX_WDOG_PWR);
  assign settle_done = xt_tick & (st_ff.cnt == CNT_LAST);
  assign pf_wake     = st_ff.keep_ref & st_ff.pf_en & warn_low;

  // Next state of the whole block
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.xt_prev   = sy[0];
    nxt_st.wake_prev = sy[1];
    nxt_st.pf_vec    = `PF_VECTOR;
    // Supply sequencing
    case (st_ff.por)
      pwr_clk_pkg::POR_HOLD:
      begin
        nxt_st.cnt = '0;
        if (sy[2])
          nxt_st.por = pwr_clk_pkg::POR_SETTLE;
      end
      pwr_clk_pkg::POR_SETTLE:
      begin
        if (settle_done)
        begin
          nxt_st.por = pwr_clk_pkg::POR_RUN;
          nxt_st.cnt = '0;
        end
        else if (xt_tick)
          nxt_st.cnt = st_ff.cnt + 17'h00001;
      end
      pwr_clk_pkg::POR_RUN:
        nxt_st.por = pwr_clk_pkg::POR_RUN;
      default:
        nxt_st.por = pwr_clk_pkg::POR_HOLD;
    endcase
    if (supply_low)
      nxt_st.por = pwr_clk_pkg::POR_HOLD;
    // Clock source sequencing, only once out of reset
    if (st_ff.rst)
      nxt_st.clk = pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY;
    else
    begin
      case (st_ff.clk)
        pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY, pwr_clk_pkg::CLK_RING:
        begin
          if (wr_power_control_reg && pwdata_in[`BIT_STOP])
            nxt_st.clk = pwr_clk_pkg::CLK_STOP;
          else if (st_ff.clk == pwr_clk_pkg::CLK_RING)
          begin
            if (settle_done)
              nxt_st.clk = pwr_clk_pkg::CLK_BREAK;
            else if (xt_tick)
              nxt_st.cnt = st_ff.cnt + 17'h00001;
          end
        end
        pwr_clk_pkg::CLK_STOP:
        begin
          // Only the pin and the supply path can end stop
          if (wake_rise || pf_wake)
          begin
            nxt_st.cnt = '0;
            nxt_st.clk = st_ff.ring_sel ? pwr_clk_pkg::CLK_RING
                                        : pwr_clk_pkg::CLK_WAIT;
          end
        end
        pwr_clk_pkg::CLK_WAIT:
        begin
          if (settle_done)
            nxt_st.clk = pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY;
          else if (xt_tick)
            nxt_st.cnt = st_ff.cnt + 17'h00001;
        end
        pwr_clk_pkg::CLK_BREAK:
        begin
          // Both gates off; crystal gate opens on a crystal edge
          if (xt_tick)
            nxt_st.clk = pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY;
        end
        default:
          nxt_st.clk = pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY;
      endcase
    end
    // Timed access: AAh then 55h opens a short window
    if (st_ff.ta_win != 2'h0)
      nxt_st.ta_win = st_ff.ta_win - 2'h1;
    if (wr)
      nxt_st.ta_armed = 1'b0;
    if (wr_ta)
    begin
      if (pwdata_in[7:0] == `TA_KEY_FIRST)
        nxt_st.ta_armed = 1'b1;
      else if (pwdata_in[7:0] == `TA_KEY_SECOND && st_ff.ta_armed)
        nxt_st.ta_win = `TA_WINDOW_CYCLES;
    end
    // Control register writes
    if (wr_extended_flag_reg)
    begin
      nxt_st.ring_sel = pwdata_in[`BIT_RING_SEL];
      if (st_ff.ta_win != 2'h0)
        nxt_st.keep_ref = pwdata_in[`BIT_KEEP_REF];
    end
    if (wr_clock_control_reg)
      nxt_st.tmr_fast = pwdata_in[`BIT_TMR2_FAST:`BIT_TMR0_FAST];
    if (wr_pmr)
      nxt_st.strobe_sup = pwdata_in[`BIT_STROBE_SUP];
    if (wr_wd)
    begin
      nxt_st.pf_en   = pwdata_in[`BIT_PF_EN];
      nxt_st.pf_flag = st_ff.pf_flag & pwdata_in[`BIT_PF_FLAG];
    end
    // Warning sets the flag whatever the enable; set beats clear.
    // Ignored while the core is held: the synchroniser wakes up low
    if (warn_low && !st_ff.rst)
      nxt_st.pf_flag = 1'b1;
    // Monitor reset returns controls to their reset values
    if (st_ff.rst)
    begin
      nxt_st.keep_ref   = 1'b0;
      nxt_st.ring_sel   = 1'b0;
      nxt_st.tmr_fast   = 3'h0;
      nxt_st.strobe_sup = 1'b0;
      nxt_st.pf_en      = 1'b0;
    end
    // Strobe and timer dividers run on crystal edges only while the crystal clocks the core
    if (st_ff.clk == pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY && xt_tick)
      nxt_st.strobe_div = st_ff.strobe_div + 2'h1;
    nxt_st.tmr_tick = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (st_ff.clk == pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY && xt_tick)
      begin
        if (st_ff.tdiv[i] >= tmr_last(st_ff.tmr_fast[i]))
        begin
          nxt_st.tdiv[i]     = 4'h0;
          nxt_st.tmr_tick[i] = 1'b1;
        end
        else
          nxt_st.tdiv[i] = st_ff.tdiv[i] + 4'h1;
      end
    end
    nxt_st.baud1_tick = nxt_st.tmr_tick[1];
    // Strobe high one crystal period of four; suppressed unless external
    nxt_st.strobe = (nxt_st.clk == pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY)
                    && (nxt_st.strobe_div == 2'h0)
                    && (!nxt_st.strobe_sup || external_data_move_in);
    // Outputs decoded from the next state
    nxt_st.rst       = (nxt_st.por != pwr_clk_pkg::POR_RUN);
    nxt_st.stop      = (nxt_st.clk == pwr_clk_pkg::CLK_STOP);
    nxt_st.crystal_frequency_gate = (nxt_st.clk == pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY);
    nxt_st.ring_gate = (nxt_st.clk == pwr_clk_pkg::CLK_RING);
    nxt_st.crystal_frequency_en   = !nxt_st.stop;
    nxt_st.ring_en   = (nxt_st.clk == pwr_clk_pkg::CLK_RING)
                       || (nxt_st.clk == pwr_clk_pkg::CLK_BREAK);
    // Keep-on bit only matters in stop
    nxt_st.ref_on    = !nxt_st.stop || nxt_st.keep_ref;
    nxt_st.pf_irq    = nxt_st.pf_en && nxt_st.pf_flag && !nxt_st.rst
                       && (nxt_st.crystal_frequency_gate || nxt_st.ring_gate);
    // APB: answer in the access phase with zero wait states
    nxt_st.pready    = setup;
    nxt_st.pslverr   = 1'b0;
    nxt_st.prdata    = `RESET_BYTE;
    if (setup)
    begin
      if (hit(paddr_in, `IDX_EXT_FLAG))
      begin
        nxt_st.prdata[`BIT_KEEP_REF] = st_ff.keep_ref;
        nxt_st.prdata[`BIT_RING_SEL] = st_ff.ring_sel;
        // Read-only status, zero on crystal
        nxt_st.prdata[`BIT_RING_ACT] =
          (st_ff.clk == pwr_clk_pkg::CLK_RING);
      end
      else if (hit(paddr_in, `IDX_CLOCK_CTRL))
        nxt_st.prdata[`BIT_TMR2_FAST:`BIT_TMR0_FAST] = st_ff.tmr_fast;
      else if (hit(paddr_in, `IDX_POWER_MGMT))
        nxt_st.prdata[`BIT_STROBE_SUP] = st_ff.strobe_sup;
      else if (hit(paddr_in, `IDX_WDOG_PWR))
      begin
        nxt_st.prdata[`BIT_PF_EN]   = st_ff.pf_en;
        nxt_st.prdata[`BIT_PF_FLAG] = st_ff.pf_flag;
      end
      else if (!hit(paddr_in, `IDX_POWER_CTRL)
               && !hit(paddr_in, `IDX_TIMED_ACCESS))
        nxt_st.pslverr = 1'b1;
    end
  end

  // State register; reset holds the core in reset with clocks on crystal
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_ff           <= '0;
      st_ff.rst       <= 1'b1;
      st_ff.crystal_frequency_en   <= 1'b1;
      st_ff.ref_on    <= 1'b1;
      st_ff.pf_vec    <= `PF_VECTOR;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register
  assign pready_out                   = st_ff.pready;
  assign prdata_out                   = {24'h000000, st_ff.prdata};
  assign pslverr_out                  = st_ff.pslverr;
  assign cpu_reset_out                = st_ff.rst;
  assign stop_mode_out                = st_ff.stop;
  assign core_crystal_frequency_gate_out           = st_ff.crystal_frequency_gate;
  assign core_ring_gate_out           = st_ff.ring_gate;
  assign crystal_enable_out           = st_ff.crystal_frequency_en;
  assign ring_osc_enable_out          = st_ff.ring_en;
  assign reference_on_out             = st_ff.ref_on;
  assign strobe_out                   = st_ff.strobe;
  assign timer_tick_out               = st_ff.tmr_tick;
  assign serial1_baud_tick_out        = st_ff.baud1_tick;
  assign early_supply_warning_irq_out = st_ff.pf_irq;
  assign irq_vector_out               = st_ff.pf_vec;

  // Checks on the sequencing
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  stop_entry_a: assert property (
    wr_power_control_reg && pwdata_in[`BIT_STOP] && !st_ff.rst && !supply_low
    && st_ff.clk == pwr_clk_pkg::CLK_CRYSTAL_FREQUENCY |=> stop_mode_out)
    else $error("stop not entered");
  stop_hold_a: assert property (
    stop_mode_out && !wake_rise && !pf_wake && !supply_low && !st_ff.rst
    |=> stop_mode_out)
    else $error("stop left without wake cause");
  ref_gate_a: assert property (
    reference_on_out == (!stop_mode_out || st_ff.keep_ref))
    else $error("reference power wrong");
  ring_wake_a: assert property (
    stop_mode_out && wake_rise && st_ff.ring_sel && !supply_low
    && !st_ff.rst |=> core_ring_gate_out && !core_crystal_frequency_gate_out)
    else $error("ring wake missing");
  ring_flag_a: assert property (
    setup && hit(paddr_in, `IDX_EXT_FLAG)
    |=> prdata_out[`BIT_RING_ACT] == $past(core_ring_gate_out))
    else $error("ring flag wrong");
  no_runt_a: assert property (
    $fell(core_ring_gate_out) && !stop_mode_out && !cpu_reset_out
    |-> !core_crystal_frequency_gate_out ##1 !core_ring_gate_out)
    else $error("ring to crystal without gap");
  strobe_sup_a: assert property (
    strobe_out |-> !st_ff.strobe_sup || $past(external_data_move_in))
    else $error("strobe not suppressed");
  pf_flag_a: assert property (
    st_ff.pf_flag && !wr_wd |=> st_ff.pf_flag)
    else $error("warning flag lost");
  ta_lock_a: assert property (
    wr_extended_flag_reg && st_ff.ta_win == 2'h0 && !st_ff.rst
    |=> $stable(st_ff.keep_ref))
    else $error("keep-on written without window");
  por_release_a: assert property (
    $fell(cpu_reset_out) |-> $past(st_ff.por == pwr_clk_pkg::POR_SETTLE))
    else $error("reset released without settle count");

  stop_ring_c: cover property (stop_mode_out ##[1:20] core_ring_gate_out);
  stop_wait_c: cover property (stop_mode_out ##1 !stop_mode_out
                               && !core_ring_gate_out);
  warn_irq_c: cover property ($rose(early_supply_warning_irq_out));
endmodule : pwr_clk_ctrl

// *** pwr_clk_ctrl_tb_top.sv ***
// Self-checking testbench of the power and clock sequencing block
module pwr_clk_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 8;
  // Bench-driven inputs
  logic clk_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, crystal_clk_in = 1'b0, ext_wake_in = 1'b0;
  logic supply_ok_in = 1'b0, supply_warn_ok_in = 1'b1;
  logic external_data_move_in = 1'b0;
  logic [9:0]  paddr_in = 10'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0]  pstrb_in = 4'hF;
  // Design outputs
  logic pready_out, pslverr_out, cpu_reset_out, stop_mode_out, strobe_out;
  logic core_crystal_frequency_gate_out, core_ring_gate_out, crystal_enable_out;
  logic ring_osc_enable_out, reference_on_out, serial1_baud_tick_out;
  logic        early_supply_warning_irq_out;
  logic [31:0] prdata_out;
  logic [2:0]  timer_tick_out;
  logic [15:0] irq_vector_out;
  // Counters and register model; model is the reference for every read
  int error_cnt = 0, check_count = 0, seed = 23, xt_cnt = 0;
  logic [1:0] xt_div = 2'h0;
  bit         ta_arm, ta_ok;
  bit         bus_held = 1'b0;
  int         mdl [256];
  logic [7:0] idx_tab [6] = '{8'h87, 8'h8E, 8'h91, 8'hC4, 8'hC7, 8'hD8};

  // Core clock, 200 MHz
  always #2.5 clk_in = ~clk_in;

  // Crystal runs only while enabled: one rise per four core cycles
  always @(posedge clk_in)
  begin
    if (crystal_enable_out === 1'b1)
    begin
      xt_div <= xt_div + 2'h1;
      crystal_clk_in <= xt_div[1];
      if (xt_div == 2'h1)
        xt_cnt <= xt_cnt + 1;
    end
  end

  pwr_clk_ctrl #(.ADDR_W(10), .SETTLE_CLOCKS(SETTLE)) pwr_clk_ctrl_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .crystal_clk_in(crystal_clk_in), .ext_wake_in(ext_wake_in),
    .supply_ok_in(supply_ok_in), .supply_warn_ok_in(supply_warn_ok_in),
    .external_data_move_in(external_data_move_in),
    .cpu_reset_out(cpu_reset_out), .stop_mode_out(stop_mode_out),
    .core_crystal_frequency_gate_out(core_crystal_frequency_gate_out),
    .core_ring_gate_out(core_ring_gate_out),
    .crystal_enable_out(crystal_enable_out),
    .ring_osc_enable_out(ring_osc_enable_out),
    .reference_on_out(reference_on_out), .strobe_out(strobe_out),
    .timer_tick_out(timer_tick_out),
    .serial1_baud_tick_out(serial1_baud_tick_out),
    .early_supply_warning_irq_out(early_supply_warning_irq_out),
    .irq_vector_out(irq_vector_out));

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] ex);
    check_count++;
    if (seen !== ex)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  function automatic logic sig(input int s);
    case (s)
      0, 1, 2: return timer_tick_out[s];
      3: return strobe_out;
      4: return cpu_reset_out;
      5: return core_ring_gate_out;
      6: return core_crystal_frequency_gate_out;
      default: return stop_mode_out;
    endcase
  endfunction : sig

  // Bounded wait, sampled 1 ns after each edge so updates have landed
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    while (sig(s) !== v && n < lim);
    if (sig(s) !== v)
    begin
      check("wait", {31'h0, sig(s)}, {31'h0, v});
      end_sim();
    end
  endtask : wait_for

  // One APB transfer; hold keeps psel up for a back-to-back successor
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, input bit hold,
                     output logic [31:0] rd, output logic err);
    int n;
    // A held bus starts its setup at the edge the last transfer ended on
    if (!bus_held)
      @(posedge clk_in);
    bus_held = hold;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {idx, 2'h0};
    pwdata_in <= {24'h0, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    #1;
    while (pready_out !== 1'b1 && n < 20)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (pready_out !== 1'b1)
    begin
      check("pready", 0, 1);
      end_sim();
    end
    // Answer stands until the next edge, where the transfer completes
    rd = prdata_out;
    err = pslverr_out;
    @(posedge clk_in);
    penable_in <= 1'b0;
    if (!hold)
      psel_in <= 1'b0;
  endtask : apb

  // Write and update the model; bit 2 of the flag register is never kept
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd,
                    input bit hold = 1'b0);
    logic [31:0] d;
    logic        e;
    int          m;
    apb(1'b1, idx, wd, hold, d, e);
    m = idx == 8'h8E ? 'h38 : idx == 8'h91 ? (ta_ok ? 'h03 : 'h02) :
        idx == 8'hC4 ? 'h04 : 0;
    if (idx == 8'hD8)
      mdl[idx] = (mdl[idx] & wd & 'h10) | (wd & 'h20);
    else
      mdl[idx] = (mdl[idx] & ~m) | (wd & m);
    ta_ok = ta_arm && idx == 8'hC7 && wd == 8'h55;
    ta_arm = idx == 8'hC7 && wd == 8'hAA;
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] extra);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 8'h00, 1'b0, d, e);
    check("prdata", d, mdl[idx] | extra);
  endtask : rd

  // Crystal edges between two pulses of a timer tick or of the strobe
  task automatic gap(input int s, input int ex);
    int t0;
    if (s == 3)
      wait_for(3, 1'b0, 40);
    wait_for(s, 1'b1, 300);
    t0 = xt_cnt;
    if (s == 3)
      wait_for(3, 1'b0, 40);
    wait_for(s, 1'b1, 300);
    check("gap", xt_cnt - t0, ex);
    if (s == 1)
      check("baud", serial1_baud_tick_out, 1'b1);
  endtask : gap

  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic        e;
    logic [7:0]  ck;
    int          t0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    #1;
    check("hold", cpu_reset_out, 1'b1);
    @(posedge clk_in);
    supply_ok_in <= 1'b1;
    t0 = xt_cnt;
    wait_for(4, 1'b0, 400);
    check("settle", xt_cnt - t0 inside {[SETTLE:SETTLE + 3]}, 1);
    foreach (idx_tab[k]) rd(idx_tab[k], 8'h00);
    apb(1'b0, 8'h10, 8'h00, 1'b0, d, e);
    check("pslverr", e, 1'b1);
    for (int k = 0; k < 3; k++) gap(k, 12);
    repeat (3)
    begin
      ck = $random(seed) & 8'h38;
      wr(8'h8E, ck);
      rd(8'h8E, 8'h00);
      for (int k = 0; k < 3; k++) gap(k, ck[3 + k] ? 4 : 12);
    end
    gap(3, 4);
    wr(8'hC4, 8'h04);
    rd(8'hC4, 8'h00);
    repeat (40) wait_for(3, 1'b0, 1);
    @(posedge clk_in);
    external_data_move_in <= 1'b1;
    wait_for(3, 1'b1, 40);
    @(posedge clk_in);
    external_data_move_in <= 1'b0;
    wr(8'hC4, 8'h00);
    // Protected bit refused without the key sequence; status bit read-only
    wr(8'h91, 8'h07);
    rd(8'h91, 8'h00);
    // Warning with interrupt disabled still sets the flag
    supply_warn_ok_in <= 1'b0;
    mdl[8'hD8] |= 'h10;
    repeat (8) @(posedge clk_in);
    #1;
    check("irq off", early_supply_warning_irq_out, 1'b0);
    @(posedge clk_in);
    supply_warn_ok_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(8'hD8, 8'h00);
    wr(8'hD8, 8'h30);
    repeat (3) @(posedge clk_in);
    #1;
    check("irq on", early_supply_warning_irq_out, 1'b1);
    check("vector", irq_vector_out, 16'h0033);
    wr(8'hD8, 8'h20);
    rd(8'hD8, 8'h00);
    #1;
    check("irq clr", early_supply_warning_irq_out, 1'b0);
    // Stop with reference off and ring wake
    wr(8'h87, 8'h02);
    wait_for(7, 1'b1, 4);
    check("stop", {core_crystal_frequency_gate_out, core_ring_gate_out,
                   crystal_enable_out, reference_on_out,
                   ring_osc_enable_out}, 5'h00);
    @(posedge clk_in);
    supply_warn_ok_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    #1;
    check("no wake", stop_mode_out, 1'b1);
    @(posedge clk_in);
    supply_warn_ok_in <= 1'b1;
    ext_wake_in <= 1'b1;
    wait_for(5, 1'b1, 10);
    check("ring en", ring_osc_enable_out, 1'b1);
    t0 = xt_cnt;
    rd(8'h91, 8'h04);
    wait_for(6, 1'b1, 400);
    check("ring n", xt_cnt - t0 inside {[SETTLE:SETTLE + 4]}, 1);
    check("ring off", core_ring_gate_out, 1'b0);
    check("ref run", reference_on_out, 1'b1);
    rd(8'h91, 8'h00);
    ext_wake_in <= 1'b0;
    // Key sequence back to back, then stop with reference kept on
    wr(8'hC7, 8'hAA, 1'b1);
    wr(8'hC7, 8'h55, 1'b1);
    wr(8'h91, 8'h01);
    rd(8'h91, 8'h00);
    wr(8'h87, 8'h02);
    wait_for(7, 1'b1, 4);
    check("ref stop", reference_on_out, 1'b1);
    @(posedge clk_in);
    supply_warn_ok_in <= 1'b0;
    mdl[8'hD8] |= 'h10;
    wait_for(7, 1'b0, 20);
    check("wait", {core_crystal_frequency_gate_out, core_ring_gate_out}, 0);
    wait_for(6, 1'b1, 400);
    @(posedge clk_in);
    supply_warn_ok_in <= 1'b1;
    rd(8'hD8, 8'h00);
    // Brownout: reset asserted, then settle count again
    supply_ok_in <= 1'b0;
    wait_for(4, 1'b1, 10);
    @(posedge clk_in);
    supply_ok_in <= 1'b1;
    wait_for(4, 1'b0, 400);
    // Monitor reset returns the flag register controls to zero
    mdl[8'h91] = 0;
    rd(8'h91, 8'h00);
    end_sim();
  end
endmodule : pwr_clk_ctrl_tb_top

// *** pwr_clk_pkg.sv ***
// Types of the power and clock sequencing block
package pwr_clk_pkg;
  typedef enum logic [1:0] {
    POR_HOLD   = 2'b00,
    POR_SETTLE = 2'b01,
    POR_RUN    = 2'b10
  } por_state_t;

  typedef enum logic [2:0] {
    CLK_CRYSTAL_FREQUENCY  = 3'b000,
    CLK_STOP  = 3'b001,
    CLK_WAIT  = 3'b010,
    CLK_RING  = 3'b011,
    CLK_BREAK = 3'b100
  } clk_state_t;

  typedef struct packed {
    por_state_t      por;
    clk_state_t      clk;
    logic [16:0]     cnt;
    logic            keep_ref;
    logic            ring_sel;
    logic [2:0]      tmr_fast;
    logic            strobe_sup;
    logic            pf_en;
    logic            pf_flag;
    logic            ta_armed;
    logic [1:0]      ta_win;
    logic [1:0]      strobe_div;
    logic [2:0][3:0] tdiv;
    logic            xt_prev;
    logic            wake_prev;
    logic            pready;
    logic            pslverr;
    logic [7:0]      prdata;
    logic            rst;
    logic            stop;
    logic            crystal_frequency_gate;
    logic            ring_gate;
    logic            crystal_frequency_en;
    logic            ring_en;
    logic            ref_on;
    logic            strobe;
    logic [2:0]      tmr_tick;
    logic            baud1_tick;
    logic            pf_irq;
    logic [15:0]     pf_vec;
  } ctrl_state_t;
endpackage : pwr_clk_pkg

// *** pwr_clk_regs.svh ***
// Register indices, bit positions and counts of the power and clock block
`ifndef PWR_CLK_REGS_SVH
`define PWR_CLK_REGS_SVH
// Register indices; byte address is four times the index
`define IDX_POWER_CTRL    8'h87
`define IDX_CLOCK_CTRL    8'h8E
`define IDX_EXT_FLAG      8'h91
`define IDX_TIMED_ACCESS  8'hC7
`define IDX_POWER_MGMT    8'hC4
`define IDX_WDOG_PWR      8'hD8
// Bit positions
`define BIT_STOP          1
`define BIT_KEEP_REF      0
`define BIT_RING_SEL      1
`define BIT_RING_ACT      2
`define BIT_STROBE_SUP    2
`define BIT_PF_FLAG       4
`define BIT_PF_EN         5
`define BIT_TMR0_FAST     3
`define BIT_TMR2_FAST     5
// Values and counts
`define RESET_BYTE        8'h00
`define TA_KEY_FIRST      8'hAA
`define TA_KEY_SECOND     8'h55
`define TA_WINDOW_CYCLES  2'h3
`define OSC_SETTLE_COUNT  65536
`define PF_VECTOR         16'h0033
`define STROBE_DIV_LAST   2'h3
`define TMR_FAST_LAST     4'h3
`define TMR_SLOW_LAST     4'hB
`endif
